// ### hsfm_fault_manager.sv
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module hsfm_fault_manager
	import hsfm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Wishbone classic slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Pins and analog comparators
	input wire logic i_logic_supply_ok,
	input wire logic i_direct_in,
	input wire logic i_frame_done,
	input wire logic [7:0] i_frame_bits,
	input wire logic [8:0] i_sense_raw,
	output logic o_output_on,
	output logic o_fault_indicator_n,
	output logic [2:0] o_overcurrent_low_threshold,
	output logic o_overcurrent_high_threshold,
	output logic o_sense_ratio_high,
	output logic o_open_load_check
);
	// ==========================================
	// Input synchronisers
	hsfm_sense_t sense_meta;
	hsfm_sense_t sense;
	logic supply_meta;
	logic supply_ok;
	logic direct_meta;
	logic direct_in;
	always_ff @(posedge i_sys_clk) begin
		sense_meta <= i_sense_raw;
		sense <= sense_meta;
		supply_meta <= i_logic_supply_ok;
		supply_ok <= supply_meta;
		direct_meta <= i_direct_in;
		direct_in <= direct_meta;
	end

	// ==========================================
	// Registers
	logic [9:0] cfg;
	logic serial_on;
	logic [9:0] blank_cnt;
	logic ot_hold;
	logic oc_latched;
	logic uv_latched;
	logic cmd_prev;
	hsfm_out_state_t out_state;
	hsfm_flags_t flags;

	// ==========================================
	// Bus decode
	wire bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire wr_ctrl = bus_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == ADDR_CTRL);
	wire wr_cfg = bus_req && i_wb_we && (i_wb_adr == ADDR_CFG);
	// Fault register read over the bus is the valid serial-read stand-in
	wire rd_fault = bus_req && !i_wb_we && (i_wb_adr == ADDR_FAULT);
	// Only whole-byte frames count as valid reads
	wire frame_valid = i_frame_done && (i_frame_bits[2:0] == 3'h0)
		&& (i_frame_bits != 8'h00);
	wire clear_flags = frame_valid || rd_fault;

	// Configuration falls back to defaults whenever logic supply is gone
	wire [9:0] cfg_eff = supply_ok ? cfg : CFG_RESET;
	wire overvoltage_disable = cfg_eff[CFG_OVERVOLTAGE_DISABLE_BIT];
	wire undervoltage_disable = cfg_eff[CFG_UNDERVOLTAGE_DISABLE_BIT];
	wire open_load_disable = cfg_eff[CFG_OPEN_LOAD_DISABLE_BIT];
	wire [1:0] blank_sel = cfg_eff[CFG_BLANK_LSB +: 2];
	// Widened first so the longest blank time does not shift out
	wire [9:0] blank_limit = {2'b00, BLANK_BASE_CYCLES} << blank_sel;

	// Output command from pin or serial bit
	wire cmd_on = direct_in || (serial_on && supply_ok);
	wire cmd_rise = cmd_on && !cmd_prev;

	wire ov_active = sense.overvoltage && !overvoltage_disable;
	wire uv_active = sense.undervoltage && !undervoltage_disable;
	wire ot_active = sense.overtemp && (out_state == OUT_ON);
	wire ol_active = sense.open_load && sense.gate_low && !cmd_on && !open_load_disable;
	wire oc_low_hit = sense.oc_low && (out_state == OUT_ON);
	wire oc_low_trip = oc_low_hit && (blank_cnt >= blank_limit);
	wire oc_high_trip = sense.oc_high && (out_state == OUT_ON);

	// Any reason to hold the output off right now
	wire force_off = ov_active || uv_active || sense.overtemp || sense.uv_deep
		|| sense.gnd_lost || oc_latched || uv_latched;

	// ==========================================
	// Control and configuration registers
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || !supply_ok) begin
			cfg <= CFG_RESET;
			serial_on <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg <= i_wb_dat[9:0];
			end
			if (wr_ctrl) begin
				serial_on <= i_wb_dat[0];
			end
		end
	end

	// ==========================================
	// Overcurrent blank timer and latches
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			blank_cnt <= 10'h000;
			cmd_prev <= 1'b0;
			ot_hold <= 1'b0;
			oc_latched <= 1'b0;
			uv_latched <= 1'b0;
		end else begin
			cmd_prev <= cmd_on;
			blank_cnt <= oc_low_hit ? ((blank_cnt == 10'h3ff) ? blank_cnt : blank_cnt + 10'h001)
				: 10'h000;
			// Output is off while hot, so live sensing is blind; hold the fault
			if (ot_active) begin
				ot_hold <= 1'b1;
			end else if (!sense.overtemp) begin
				ot_hold <= 1'b0;
			end
			if (oc_low_trip || oc_high_trip) begin
				oc_latched <= 1'b1;
			end else if (!cmd_on) begin
				oc_latched <= 1'b0;
			end
			// Undervoltage while commanded on latches until re-command
			if (uv_active && cmd_on) begin
				uv_latched <= 1'b1;
			end else if (!cmd_on) begin
				uv_latched <= 1'b0;
			end
		end
	end

	// ==========================================
	// Output state
	hsfm_out_state_t next_out_state;
	always_comb begin
		next_out_state = out_state;
		case (out_state)
			OUT_OFF: begin
				if (cmd_on && !force_off) begin
					next_out_state = OUT_ON;
				end
			end
			OUT_ON: begin
				if (oc_low_trip || oc_high_trip) begin
					next_out_state = OUT_LATCHED;
				end else if (!cmd_on || force_off) begin
					next_out_state = OUT_OFF;
				end
			end
			OUT_LATCHED: begin
				if (!cmd_on) begin
					next_out_state = OUT_OFF;
				end
			end
			default: next_out_state = OUT_OFF;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			out_state <= OUT_OFF;
		end else begin
			out_state <= next_out_state;
		end
	end

	// ==========================================
	// Sticky fault flags
	wire [5:0] flag_set = {ol_active, uv_active, ov_active, ot_active, oc_high_trip, oc_low_trip};
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_flag
			hsfm_flag u_flag (
				.i_sys_clk(i_sys_clk),
				.i_reset_n(i_reset_n),
				.i_set(flag_set[g]),
				.i_clear(clear_flags),
				.o_flag(flags[g])
			);
		end
	endgenerate

	// ==========================================
	// Pin outputs
	wire fault_live = ov_active || uv_active || ot_active || ol_active
		|| ot_hold || oc_latched || uv_latched;
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_fault_indicator_n <= 1'b1;
			o_output_on <= 1'b0;
			o_overcurrent_low_threshold <= 3'h0;
			o_overcurrent_high_threshold <= 1'b0;
			o_sense_ratio_high <= 1'b0;
			o_open_load_check <= 1'b0;
		end else begin
			o_fault_indicator_n <= !fault_live;
			o_output_on <= (next_out_state == OUT_ON);
			o_overcurrent_low_threshold <= cfg_eff[CFG_OCL_LSB +: 3];
			o_overcurrent_high_threshold <= cfg_eff[CFG_OCH_BIT];
			o_sense_ratio_high <= cfg_eff[CFG_SENSE_BIT];
			o_open_load_check <= !cmd_on && !open_load_disable;
		end
	end

	// ==========================================
	// Bus read and ack
	wire [31:0] status_word = {22'h0, supply_ok, cmd_on, oc_latched, uv_latched,
		!o_fault_indicator_n, o_output_on, 2'h0, out_state};
	// Overvoltage sits in bit one of the fault word; the status word has no overvoltage bit
	wire [31:0] fault_word = {26'h0, flags.open_load, flags.undervoltage, flags.oc_high,
		flags.oc_low, flags.overvoltage, flags.overtemp};
	wire [31:0] rd_mux = (i_wb_adr == ADDR_CTRL) ? {31'h0, serial_on} :
		(i_wb_adr == ADDR_CFG) ? {22'h0, cfg} :
		(i_wb_adr == ADDR_STATUS) ? status_word :
		(i_wb_adr == ADDR_FAULT) ? fault_word : 32'h0;
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= bus_req;
			o_wb_dat <= bus_req ? rd_mux : 32'h0;
		end
	end

	// ==========================================
	// Checks
	a_ot_flag_sets: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		ot_active && !clear_flags |=> flags.overtemp) else $error("overtemp flag not set");
	a_ov_disabled: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		overvoltage_disable && !flags.overvoltage |=> !flags.overvoltage)
		else $error("overvoltage reported while disabled");
	a_high_oc_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		oc_high_trip |=> !o_output_on ##1 !o_output_on) else $error("high overcurrent kept on");
	a_latch_holds: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		out_state == OUT_LATCHED && cmd_on |=> !o_output_on) else $error("latch released early");
	a_uv_pin_low: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		uv_active |=> !o_fault_indicator_n) else $error("undervoltage pin not low");
	a_gnd_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		sense.gnd_lost |=> !o_output_on) else $error("ground loss left output on");
	a_clear_read: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		clear_flags && flag_set == 6'h0 |=> flags == 6'h0) else $error("flags not cleared");
	a_bad_frame: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_frame_done && i_frame_bits[2:0] != 3'h0 && !rd_fault |-> !clear_flags)
		else $error("short frame cleared flags");
	a_supply_defaults: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!supply_ok |=> cfg == CFG_RESET) else $error("config kept without supply");

	// ==========================================
	// Named sequences and further checks
	sequence s_uv_recover_on;
		uv_latched && cmd_on;
	endsequence
	sequence s_latch_reissue;
		out_state == OUT_LATCHED ##1 !cmd_on;
	endsequence
	sequence s_good_frame;
		frame_valid && flag_set == 6'h0;
	endsequence
	a_ot_pin_low: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		ot_active |=> !o_fault_indicator_n)
		else $error("overtemp pin not low");
	a_ot_hold_pin: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		ot_hold && sense.overtemp |=> !o_fault_indicator_n)
		else $error("overtemp pin released while hot");
	a_ov_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		ov_active |=> !o_output_on)
		else $error("overvoltage left output on");
	a_ov_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		ov_active |=> flags.overvoltage)
		else $error("overvoltage flag not set");
	a_uv_flag: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		uv_active |=> flags.undervoltage)
		else $error("undervoltage flag not set");
	a_uv_deep_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		sense.uv_deep |=> !o_output_on)
		else $error("deep undervoltage left output on");
	a_undervoltage_disable_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		undervoltage_disable && !flags.undervoltage |=> !flags.undervoltage)
		else $error("undervoltage reported while disabled");
	a_ol_only_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		cmd_on && !flags.open_load |=> !flags.open_load)
		else $error("open load flagged while on");
	a_ol_disabled: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		open_load_disable && !flags.open_load |=> !flags.open_load)
		else $error("open load flagged while disabled");
	a_ot_armed_on: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		out_state != OUT_ON && !flags.overtemp |=> !flags.overtemp)
		else $error("overtemp flagged while off");
	a_low_oc_wait: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		oc_low_hit && (blank_cnt < blank_limit) && !sense.oc_high |=> out_state != OUT_LATCHED)
		else $error("low overcurrent tripped early");
	a_latch_release: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_latch_reissue |=> out_state == OUT_OFF)
		else $error("latch not released by command off");
	a_uv_recover_on: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_uv_recover_on |=> !o_fault_indicator_n && !o_output_on)
		else $error("undervoltage latch released early");
	a_oc_pin_held: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		oc_latched |=> !o_fault_indicator_n)
		else $error("overcurrent pin released");
	a_direct_drives: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!supply_ok && direct_in && !force_off && out_state == OUT_OFF |=> o_output_on)
		else $error("direct input ignored without supply");
	a_sense_default: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!supply_ok |=> !o_sense_ratio_high)
		else $error("sense ratio not default");
	a_thr_default: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!supply_ok |=> o_overcurrent_low_threshold == 3'h0 && !o_overcurrent_high_threshold)
		else $error("thresholds not default");
	a_frame_clears: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_good_frame |=> flags == 6'h0)
		else $error("whole frame did not clear flags");
endmodule // hsfm_fault_manager
`default_nettype wire

// ### hsfm_pkg.sv
`default_nettype none
package hsfm_pkg;
	// ==========================================
	// Register map (word offsets as byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FAULT = 8'h0c;
	// ==========================================
	// Field positions
	localparam int CFG_OCL_LSB = 0;
	localparam int CFG_OCH_BIT = 3;
	localparam int CFG_BLANK_LSB = 4;
	localparam int CFG_OVERVOLTAGE_DISABLE_BIT = 6;
	localparam int CFG_UNDERVOLTAGE_DISABLE_BIT = 7;
	localparam int CFG_OPEN_LOAD_DISABLE_BIT = 8;
	localparam int CFG_SENSE_BIT = 9;
	// ==========================================
	// Reset values and counts
	localparam logic [9:0] CFG_RESET = 10'h000;
	localparam logic [7:0] BLANK_BASE_CYCLES = 8'h40;
	localparam int FRAME_BITS = 8;

	typedef struct packed {
		logic overtemp;
		logic overvoltage;
		logic undervoltage;
		logic uv_deep;
		logic open_load;
		logic oc_low;
		logic oc_high;
		logic gnd_lost;
		logic gate_low;
	} hsfm_sense_t;

	typedef struct packed {
		logic open_load;
		logic undervoltage;
		logic overvoltage;
		logic overtemp;
		logic oc_high;
		logic oc_low;
	} hsfm_flags_t;

	typedef enum logic [1:0] {
		OUT_OFF = 2'b00,
		OUT_ON = 2'b01,
		OUT_LATCHED = 2'b11
	} hsfm_out_state_t;
endpackage
`default_nettype wire

// ### hsfm_flag.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sticky fault flag, set wins over clear
module hsfm_flag (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_flag
);
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clear) begin
			o_flag <= 1'b0;
		end
	end
endmodule // hsfm_flag
`default_nettype wire

// ### hsfm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side: serial frame reports and direct input pin
module hsfm_host_model (
	input wire logic i_sys_clk,
	output logic o_frame_done,
	output logic [7:0] o_frame_bits,
	output logic o_direct_in
);
	initial begin
		o_frame_done = 1'b0;
		o_frame_bits = 8'h00;
		o_direct_in = 1'b0;
	end
	// Odd bit counts only when a test asks for them
	task automatic send_frame(input logic [7:0] bits);
		@(posedge i_sys_clk);
		o_frame_done <= 1'b1;
		o_frame_bits <= bits;
		@(posedge i_sys_clk);
		o_frame_done <= 1'b0;
		// Count is stale after the pulse, so show something else
		o_frame_bits <= ~bits;
	endtask
	task automatic set_direct(input logic level);
		@(posedge i_sys_clk);
		o_direct_in <= level;
	endtask
endmodule // hsfm_host_model
`default_nettype wire

// ### test_high_side_fault_manager.sv
`timescale 1ns/1ps
`default_nettype none
module test_high_side_fault_manager;
	import hsfm_pkg::*;
	logic i_sys_clk, i_reset_n, req, we, sup, on, fault_n, ack, fd, di;
	logic [7:0] adr, fb;
	logic [31:0] wdat, rdat, q;
	logic [2:0] thr;
	logic thh, srh, olc;
	hsfm_sense_t sense;
	int n_mismatch = 0;
	int total_checks = 0;
	hsfm_host_model host (.i_sys_clk(i_sys_clk), .o_frame_done(fd), .o_frame_bits(fb),
		.o_direct_in(di));
	hsfm_fault_manager dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wb_cyc(req),
		.i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_logic_supply_ok(sup), .i_direct_in(di),
		.i_frame_done(fd), .i_frame_bits(fb), .i_sense_raw(sense), .o_output_on(on),
		.o_fault_indicator_n(fault_n), .o_overcurrent_low_threshold(thr),
		.o_overcurrent_high_threshold(thh), .o_sense_ratio_high(srh), .o_open_load_check(olc));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// ==========================================
	// Shared tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_sys_clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		q = rdat;
		req <= 1'b0;
		if (ack !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
		@(posedge i_sys_clk);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic settle;
		repeat (6) @(posedge i_sys_clk);
	endtask
	// Expected {output on, fault pin}
	task automatic pins(input logic [1:0] e);
		chk("pins", {30'h0, on, fault_n}, {30'h0, e});
	endtask
	task automatic recmd;
		wb(1'b1, ADDR_CTRL, 32'h0);
		wb(1'b1, ADDR_CTRL, 32'h1);
		settle();
	endtask
	task automatic heat;
		sense.overtemp <= 1'b1;
		settle();
		sense.overtemp <= 1'b0;
		settle();
	endtask
	initial begin
		repeat (90000) @(posedge i_sys_clk);
		n_mismatch++;
		conclude();
	end
	// ==========================================
	// Main sequence
	initial begin
		i_reset_n = 1'b0;
		req = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		sup = 1'b1;
		sense = '0;
		repeat (2) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		@(posedge i_sys_clk);
		pins(2'b01);
		rdc("cfg", ADDR_CFG, 32'h0);
		rdc("status", ADDR_STATUS, 32'h200);
		rdc("unmapped", 8'h10, 32'h0);
		wb(1'b1, ADDR_CTRL, 32'h1);
		settle();
		pins(2'b11);
		sense.oc_high <= 1'b1;
		settle();
		pins(2'b00);
		sense.oc_high <= 1'b0;
		settle();
		pins(2'b00);
		rdc("fault", ADDR_FAULT, 32'h8);
		rdc("fault", ADDR_FAULT, 32'h0);
		recmd();
		pins(2'b11);
		// Blank select 0 holds off the low trip for 64 cycles
		sense.oc_low <= 1'b1;
		repeat (40) @(posedge i_sys_clk);
		pins(2'b11);
		repeat (60) @(posedge i_sys_clk);
		pins(2'b00);
		sense.oc_low <= 1'b0;
		rdc("fault", ADDR_FAULT, 32'h4);
		recmd();
		sense.overtemp <= 1'b1;
		settle();
		pins(2'b00);
		sense.overtemp <= 1'b0;
		settle();
		pins(2'b11);
		host.send_frame(8'h07);
		rdc("fault", ADDR_FAULT, 32'h1);
		heat();
		host.send_frame(8'h10);
		rdc("fault", ADDR_FAULT, 32'h0);
		sense.overvoltage <= 1'b1;
		settle();
		pins(2'b00);
		sense.overvoltage <= 1'b0;
		settle();
		pins(2'b11);
		rdc("fault", ADDR_FAULT, 32'h2);
		wb(1'b1, ADDR_CFG, 32'h40);
		sense.overvoltage <= 1'b1;
		settle();
		pins(2'b11);
		sense.overvoltage <= 1'b0;
		rdc("fault", ADDR_FAULT, 32'h0);
		wb(1'b1, ADDR_CFG, 32'h0);
		sense.undervoltage <= 1'b1;
		settle();
		pins(2'b00);
		sense.undervoltage <= 1'b0;
		settle();
		pins(2'b00);
		rdc("fault", ADDR_FAULT, 32'h10);
		recmd();
		pins(2'b11);
		wb(1'b1, ADDR_CTRL, 32'h0);
		sense.undervoltage <= 1'b1;
		settle();
		sense.undervoltage <= 1'b0;
		settle();
		pins(2'b01);
		rdc("fault", ADDR_FAULT, 32'h10);
		wb(1'b1, ADDR_CFG, 32'h80);
		wb(1'b1, ADDR_CTRL, 32'h1);
		sense.undervoltage <= 1'b1;
		settle();
		pins(2'b11);
		sense.uv_deep <= 1'b1;
		settle();
		pins(2'b01);
		sense.undervoltage <= 1'b0;
		sense.uv_deep <= 1'b0;
		rdc("fault", ADDR_FAULT, 32'h0);
		wb(1'b1, ADDR_CTRL, 32'h0);
		wb(1'b1, ADDR_CFG, 32'h0);
		sense.open_load <= 1'b1;
		sense.gate_low <= 1'b1;
		settle();
		pins(2'b00);
		chk("olc", 32'(olc), 32'h1);
		rdc("fault", ADDR_FAULT, 32'h20);
		wb(1'b1, ADDR_CFG, 32'h100);
		settle();
		pins(2'b01);
		chk("olc", 32'(olc), 32'h0);
		sense.open_load <= 1'b0;
		wb(1'b1, ADDR_CTRL, 32'h1);
		sense.gnd_lost <= 1'b1;
		settle();
		chk("on", 32'(on), 32'h0);
		sense.gnd_lost <= 1'b0;
		wb(1'b1, ADDR_CFG, 32'h20d);
		settle();
		rdc("cfg", ADDR_CFG, 32'h20d);
		chk("thr", 32'(thr), 32'h5);
		chk("thh", 32'(thh), 32'h1);
		chk("srh", 32'(srh), 32'h1);
		sup <= 1'b0;
		settle();
		chk("thr", 32'(thr), 32'h0);
		chk("thh", 32'(thh), 32'h0);
		chk("srh", 32'(srh), 32'h0);
		host.set_direct(1'b1);
		settle();
		chk("on", 32'(on), 32'h1);
		sup <= 1'b1;
		settle();
		rdc("cfg", ADDR_CFG, 32'h0);
		conclude();
	end
endmodule // test_high_side_fault_manager
`default_nettype wire
